// *** logic/tsu_pkg.sv ***
package tsu_pkg;
  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int unsigned CLK_HZ = 25_000_000;
  localparam int unsigned OSC_STOP_MS = 10;
  localparam int unsigned OSC_STOP_CYC = OSC_STOP_MS * (CLK_HZ / 1000);
  localparam int unsigned OSC_CNT_W = 18;

  // ------------------------------------------------------------
  // Banks and offsets
  // ------------------------------------------------------------
  localparam logic [2:0] BANK_CLK = 3'h1;
  localparam logic [2:0] BANK_STAMP = 3'h2;
  localparam logic [2:0] BANK_STORE_CTL = 3'h3;
  localparam logic [3:0] A_EXT = 4'hd;
  localparam logic [3:0] A_FLAG = 4'he;
  localparam logic [3:0] A_CTRL = 4'hf;
  localparam logic [3:0] A_STAT = 4'h9;
  localparam logic [3:0] A_OVW = 4'hb;
  localparam logic [3:0] A_TSC0 = 4'he;
  localparam logic [3:0] A_TRIG = 4'hf;
  localparam logic [3:0] A_TSC1 = 4'h4;
  localparam logic [3:0] A_TSC2 = 4'h5;
  localparam logic [3:0] A_TSC3 = 4'h6;

  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int FLAG_EVENT = 2;
  localparam int FLAG_OSC = 0;
  localparam int CTRL_EIE = 2;
  localparam int OVW_EN = 1;
  localparam int TSC0_TRIG_EN = 0;
  localparam int TSC1_FULL_SEL = 2;
  localparam int TSC1_CLEAR = 1;
  localparam int TSC1_RAM_SEL = 0;
  localparam int TSC2_SUPPLY_LOW_STATE_EN = 2;
  localparam int TSC2_OSC_EN = 0;
  localparam int TSC3_FULL = 4;
  localparam int TSC3_EMPTY = 3;
  localparam int STAT_SUPPLY_LOW_STATE = 3;
  localparam int STAT_OSC = 1;

  // ------------------------------------------------------------
  // Sizes and reset values
  // ------------------------------------------------------------
  localparam int STAMP_BYTES = 10;
  localparam int REC_BYTES = 8;
  localparam int STORE_BYTES = 64;
  localparam logic [7:0] REG_RST = 8'h00;
  localparam logic [7:0] TRIG_READ_VAL = 8'h00;
  localparam logic [2:0] PTR_RST = 3'h7;

  // ------------------------------------------------------------
  // Types
  // ------------------------------------------------------------
  typedef struct packed {
    logic [7:0] sub_fine;
    logic [7:0] sub_coarse;
    logic [7:0] sec;
    logic [7:0] min;
    logic [7:0] hour;
    logic [7:0] week;
    logic [7:0] date;
    logic [7:0] month;
    logic [7:0] year;
  } tsu_time_t;

  typedef struct packed {
    logic rd;
    logic [2:0] bank;
    logic [3:0] addr;
  } tsu_cmd_t;

  typedef enum {TSU_IDLE, TSU_CMD, TSU_DATA} tsu_spi_st_t;
endpackage

// *** logic/tsu_time_stamp.sv ***
`timescale 1ns/1ns
module tsu_time_stamp #(
  parameter int unsigned OSC_STOP_CYC = tsu_pkg::OSC_STOP_CYC
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic spi_sck,
  input wire logic spi_cs_n,
  input wire logic spi_mosi,
  output logic spi_miso,
  output logic spi_miso_oe_n,
  output logic int_n,
  output logic int_n_oe_n,
  input wire tsu_pkg::tsu_time_t time_now,
  input wire logic supply_low,
  input wire logic osc_halt
);
  // ------------------------------------------------------------
  // Synchronisers
  // ------------------------------------------------------------
  logic [1:0] sck_s_q, cs_s_q, mosi_s_q, supply_low_state_s_q, halt_s_q;
  logic sck_p_q, supply_low_state_p_q, halt_p_q;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sck_s_q <= 2'h0;
      cs_s_q <= 2'h3;
      mosi_s_q <= 2'h0;
      supply_low_state_s_q <= 2'h0;
      halt_s_q <= 2'h0;
      sck_p_q <= 1'b0;
      supply_low_state_p_q <= 1'b0;
      halt_p_q <= 1'b0;
    end else begin
      sck_s_q <= {sck_s_q[0], spi_sck};
      cs_s_q <= {cs_s_q[0], spi_cs_n};
      mosi_s_q <= {mosi_s_q[0], spi_mosi};
      supply_low_state_s_q <= {supply_low_state_s_q[0], supply_low};
      halt_s_q <= {halt_s_q[0], osc_halt};
      sck_p_q <= sck_s_q[1];
      supply_low_state_p_q <= supply_low_state_s_q[1];
      halt_p_q <= halt_s_q[1];
    end
  end

  logic sck_rise, sck_fall, cs_act;
  assign sck_rise = sck_s_q[1] & ~sck_p_q;
  assign sck_fall = ~sck_s_q[1] & sck_p_q;
  assign cs_act = ~cs_s_q[1];

  // ------------------------------------------------------------
  // Serial slave
  // ------------------------------------------------------------
  tsu_pkg::tsu_spi_st_t st_q, st_d;
  tsu_pkg::tsu_cmd_t cmd_q, cmd_d;
  logic [2:0] bitc_q, bitc_d;
  logic [7:0] sh_in_q, sh_in_d, sh_out_q, sh_out_d, in_byte, rd_data;
  logic miso_q, miso_d, miso_oe_n_q, miso_oe_n_d;
  logic rd_req, wr_req;
  logic [2:0] rd_bank;
  logic [3:0] rd_addr;

  always_comb begin
    st_d = st_q;
    cmd_d = cmd_q;
    bitc_d = bitc_q;
    sh_in_d = sh_in_q;
    sh_out_d = sh_out_q;
    miso_d = miso_q;
    miso_oe_n_d = miso_oe_n_q;
    in_byte = {sh_in_q[6:0], mosi_s_q[1]};
    rd_req = 1'b0;
    wr_req = 1'b0;
    rd_bank = cmd_q.bank;
    rd_addr = cmd_q.addr + 4'h1;
    if (!cs_act) begin
      st_d = tsu_pkg::TSU_IDLE;
      bitc_d = 3'h0;
      sh_out_d = 8'h00;
      miso_oe_n_d = 1'b1;
    end else begin
      if (st_q == tsu_pkg::TSU_IDLE) begin
        st_d = tsu_pkg::TSU_CMD;
      end
      if (sck_rise) begin
        sh_in_d = in_byte;
        bitc_d = bitc_q + 3'h1;
        if (bitc_q == 3'h7 && st_q == tsu_pkg::TSU_CMD) begin
          cmd_d = in_byte;
          st_d = tsu_pkg::TSU_DATA;
          rd_req = in_byte[7];
          rd_bank = in_byte[6:4];
          rd_addr = in_byte[3:0];
        end else if (bitc_q == 3'h7 && st_q == tsu_pkg::TSU_DATA) begin
          rd_req = cmd_q.rd;
          wr_req = ~cmd_q.rd;
          cmd_d.addr = cmd_q.addr + 4'h1;
        end
      end
      if (sck_fall && st_q == tsu_pkg::TSU_DATA && cmd_q.rd) begin
        miso_d = sh_out_q[7];
        sh_out_d = {sh_out_q[6:0], 1'b0};
        miso_oe_n_d = 1'b0;
      end
      if (rd_req) begin
        sh_out_d = rd_data;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= tsu_pkg::TSU_IDLE;
      cmd_q <= '0;
      bitc_q <= 3'h0;
      sh_in_q <= 8'h00;
      sh_out_q <= 8'h00;
      miso_q <= 1'b0;
      miso_oe_n_q <= 1'b1;
    end else begin
      st_q <= st_d;
      cmd_q <= cmd_d;
      bitc_q <= bitc_d;
      sh_in_q <= sh_in_d;
      sh_out_q <= sh_out_d;
      miso_q <= miso_d;
      miso_oe_n_q <= miso_oe_n_d;
    end
  end

  // ------------------------------------------------------------
  // Registers, monitors and capture
  // ------------------------------------------------------------
  logic [7:0] ext_q, ext_d, ctrl_q, ctrl_d, ovw_q, ovw_d, tsc0_q, tsc0_d;
  logic [7:0] tsc1_q, tsc1_d, tsc2_q, tsc2_d, stat_b;
  logic [7:0] stamp_q [tsu_pkg::STAMP_BYTES];
  logic [7:0] stamp_d [tsu_pkg::STAMP_BYTES];
  logic [7:0] mem_q [tsu_pkg::STORE_BYTES];
  logic [7:0] mem_d [tsu_pkg::STORE_BYTES];
  logic [7:0] rec_b [tsu_pkg::REC_BYTES];
  logic [2:0] ptr_q, ptr_d;
  logic full_q, full_d, empty_q, empty_d;
  logic ev_flag_q, ev_flag_d, osc_st_q, osc_st_d, int_oe_n_q, int_oe_n_d;
  logic [tsu_pkg::OSC_CNT_W-1:0] halt_cnt_q, halt_cnt_d;
  logic flag_wr, flag_clr, osc_clr, cmd_trig;
  logic supply_low_state_evt, xst_evt, dev_evt, capture, store_ok;
  logic [7:0] wdat;

  assign wdat = in_byte;
  assign flag_wr = wr_req && cmd_q.bank == tsu_pkg::BANK_CLK
      && cmd_q.addr == tsu_pkg::A_FLAG;
  assign flag_clr = flag_wr && !wdat[tsu_pkg::FLAG_EVENT];
  assign osc_clr = flag_wr && !wdat[tsu_pkg::FLAG_OSC];
  assign cmd_trig = rd_req && rd_bank == tsu_pkg::BANK_STAMP
      && rd_addr == tsu_pkg::A_TRIG && tsc0_q[tsu_pkg::TSC0_TRIG_EN];
  assign supply_low_state_evt = supply_low_state_s_q[1] && !supply_low_state_p_q
      && tsc2_q[tsu_pkg::TSC2_SUPPLY_LOW_STATE_EN];
  assign xst_evt = halt_p_q && !halt_s_q[1] && osc_st_q
      && tsc2_q[tsu_pkg::TSC2_OSC_EN];
  assign dev_evt = supply_low_state_evt || xst_evt;
  assign capture = cmd_trig || dev_evt;
  assign store_ok = tsc1_q[tsu_pkg::TSC1_RAM_SEL]
      && (!full_q || ovw_q[tsu_pkg::OVW_EN]);

  always_comb begin
    stat_b = 8'h00;
    stat_b[tsu_pkg::STAT_SUPPLY_LOW_STATE] = supply_low_state_s_q[1];
    stat_b[tsu_pkg::STAT_OSC] = osc_st_q;
  end

  // Status byte replaces the unrecorded fine and weekday fields in store
  assign rec_b = '{time_now.sub_coarse, time_now.sec, time_now.min,
      time_now.hour, time_now.date, time_now.month, time_now.year, stat_b};

  always_comb begin
    rd_data = 8'h00;
    case (rd_bank)
      tsu_pkg::BANK_CLK: begin
        case (rd_addr)
          tsu_pkg::A_EXT: rd_data = ext_q;
          tsu_pkg::A_CTRL: rd_data = ctrl_q;
          tsu_pkg::A_FLAG: begin
            rd_data[tsu_pkg::FLAG_EVENT] = ev_flag_q;
            rd_data[tsu_pkg::FLAG_OSC] = osc_st_q;
          end
          default: rd_data = 8'h00;
        endcase
      end
      tsu_pkg::BANK_STAMP: begin
        if (rd_addr < 4'(tsu_pkg::STAMP_BYTES)) begin
          rd_data = stamp_q[rd_addr];
        end else if (rd_addr == tsu_pkg::A_OVW) begin
          rd_data = ovw_q;
        end else if (rd_addr == tsu_pkg::A_TSC0) begin
          rd_data = tsc0_q;
        end else begin
          rd_data = tsu_pkg::TRIG_READ_VAL;
        end
      end
      tsu_pkg::BANK_STORE_CTL: begin
        case (rd_addr)
          tsu_pkg::A_TSC1: rd_data = tsc1_q;
          tsu_pkg::A_TSC2: rd_data = tsc2_q;
          tsu_pkg::A_TSC3: begin
            rd_data[tsu_pkg::TSC3_FULL] = full_q;
            rd_data[tsu_pkg::TSC3_EMPTY] = empty_q;
            rd_data[2:0] = ptr_q;
          end
          default: rd_data = 8'h00;
        endcase
      end
      3'h4, 3'h5, 3'h6, 3'h7: rd_data = mem_q[{rd_bank[1:0], rd_addr}];
      default: rd_data = 8'h00;
    endcase
  end

  always_comb begin
    ext_d = ext_q;
    ctrl_d = ctrl_q;
    ovw_d = ovw_q;
    tsc0_d = tsc0_q;
    tsc1_d = tsc1_q;
    tsc2_d = tsc2_q;
    stamp_d = stamp_q;
    mem_d = mem_q;
    ptr_d = ptr_q;
    full_d = full_q;
    empty_d = empty_q;
    ev_flag_d = ev_flag_q;
    osc_st_d = osc_st_q;
    int_oe_n_d = int_oe_n_q;
    halt_cnt_d = halt_s_q[1] ? halt_cnt_q : '0;
    tsc1_d[tsu_pkg::TSC1_CLEAR] = 1'b0;
    if (wr_req) begin
      case ({cmd_q.bank, cmd_q.addr})
        {tsu_pkg::BANK_CLK, tsu_pkg::A_EXT}: ext_d = wdat;
        {tsu_pkg::BANK_CLK, tsu_pkg::A_CTRL}: ctrl_d = wdat;
        {tsu_pkg::BANK_STAMP, tsu_pkg::A_OVW}: ovw_d = wdat;
        {tsu_pkg::BANK_STAMP, tsu_pkg::A_TSC0}: tsc0_d = wdat;
        {tsu_pkg::BANK_STORE_CTL, tsu_pkg::A_TSC1}: tsc1_d = wdat;
        {tsu_pkg::BANK_STORE_CTL, tsu_pkg::A_TSC2}: tsc2_d = wdat;
        default: begin
          if (cmd_q.bank[2]) begin
            mem_d[{cmd_q.bank[1:0], cmd_q.addr}] = wdat;
          end
        end
      endcase
    end
    if (wr_req && cmd_q.bank == tsu_pkg::BANK_STORE_CTL
        && cmd_q.addr == tsu_pkg::A_TSC1 && wdat[tsu_pkg::TSC1_CLEAR]) begin
      ptr_d = tsu_pkg::PTR_RST;
      full_d = 1'b0;
      empty_d = 1'b1;
    end
    if (osc_clr) begin
      osc_st_d = 1'b0;
    end
    if (halt_s_q[1]) begin
      if (halt_cnt_q != tsu_pkg::OSC_CNT_W'(OSC_STOP_CYC)) begin
        halt_cnt_d = halt_cnt_q + 1'b1;
      end else begin
        osc_st_d = 1'b1;
      end
    end
    if (flag_clr) begin
      ev_flag_d = 1'b0;
      int_oe_n_d = 1'b1;
    end
    if (capture) begin
      // One cycle copy of the running time keeps the record consistent
      stamp_d = '{time_now.sub_fine, time_now.sub_coarse, time_now.sec,
          time_now.min, time_now.hour, time_now.week, time_now.date,
          time_now.month, time_now.year, stat_b};
      if (store_ok) begin
        ptr_d = ptr_q + 3'h1;
        empty_d = 1'b0;
        if (ptr_d == tsu_pkg::PTR_RST) begin
          full_d = 1'b1;
        end
        for (int i = 0; i < tsu_pkg::REC_BYTES; i++) begin
          mem_d[{ptr_d, 3'(i)}] = rec_b[i];
        end
      end
    end
    if (dev_evt) begin
      ev_flag_d = 1'b1;
      if (ctrl_q[tsu_pkg::CTRL_EIE] && (!tsc1_q[tsu_pkg::TSC1_FULL_SEL]
          || (full_d && !full_q))) begin
        int_oe_n_d = 1'b0;
      end
    end
    if (!ctrl_q[tsu_pkg::CTRL_EIE]) begin
      int_oe_n_d = 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ext_q <= tsu_pkg::REG_RST;
      ctrl_q <= tsu_pkg::REG_RST;
      ovw_q <= tsu_pkg::REG_RST;
      tsc0_q <= tsu_pkg::REG_RST;
      tsc1_q <= tsu_pkg::REG_RST;
      tsc2_q <= tsu_pkg::REG_RST;
      stamp_q <= '{default: tsu_pkg::REG_RST};
      mem_q <= '{default: tsu_pkg::REG_RST};
      ptr_q <= tsu_pkg::PTR_RST;
      full_q <= 1'b0;
      empty_q <= 1'b1;
      ev_flag_q <= 1'b0;
      osc_st_q <= 1'b0;
      int_oe_n_q <= 1'b1;
      halt_cnt_q <= '0;
    end else begin
      ext_q <= ext_d;
      ctrl_q <= ctrl_d;
      ovw_q <= ovw_d;
      tsc0_q <= tsc0_d;
      tsc1_q <= tsc1_d;
      tsc2_q <= tsc2_d;
      stamp_q <= stamp_d;
      mem_q <= mem_d;
      ptr_q <= ptr_d;
      full_q <= full_d;
      empty_q <= empty_d;
      ev_flag_q <= ev_flag_d;
      osc_st_q <= osc_st_d;
      int_oe_n_q <= int_oe_n_d;
      halt_cnt_q <= halt_cnt_d;
    end
  end

  assign spi_miso = miso_q;
  assign spi_miso_oe_n = miso_oe_n_q;
  assign int_n = 1'b0;
  assign int_n_oe_n = int_oe_n_q;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  chk_trig_reads_zero: assert property (
    rd_req && rd_bank == tsu_pkg::BANK_STAMP && rd_addr == tsu_pkg::A_TRIG
    |=> sh_out_q == 8'h00)
    else $error("trigger location read not zero");
  chk_cmd_no_flag: assert property (
    cmd_trig && !dev_evt && !ev_flag_q |=> !ev_flag_q && int_oe_n_q == 
    $past(int_oe_n_q))
    else $error("bus trigger touched flag or interrupt");
  chk_event_sets_flag: assert property (
    dev_evt |=> ev_flag_q ##1 (ev_flag_q || $past(flag_clr)))
    else $error("event did not set flag");
  chk_irq_drive_low: assert property (
    dev_evt && ctrl_q[tsu_pkg::CTRL_EIE] && !tsc1_q[tsu_pkg::TSC1_FULL_SEL]
    |=> !int_oe_n_q && !int_n_oe_n)
    else $error("interrupt not driven");
  chk_irq_disabled: assert property (
    !ctrl_q[tsu_pkg::CTRL_EIE] |=> int_oe_n_q)
    else $error("interrupt active while disabled");
  chk_flag_release: assert property (
    flag_clr && !dev_evt |=> int_oe_n_q && !ev_flag_q)
    else $error("flag clear did not release interrupt");
  chk_store_hold: assert property (
    capture && tsc1_q[tsu_pkg::TSC1_RAM_SEL] && full_q
    && !ovw_q[tsu_pkg::OVW_EN] && !wr_req |=> $stable(ptr_q) && full_q)
    else $error("full store was overwritten");
  chk_trig_off: assert property (
    rd_req && rd_bank == tsu_pkg::BANK_STAMP && rd_addr == tsu_pkg::A_TRIG
    && !tsc0_q[tsu_pkg::TSC0_TRIG_EN] && !dev_evt |-> !capture)
    else $error("disabled trigger captured");
  chk_stamp_status: assert property (
    capture |=> stamp_q[9][tsu_pkg::STAT_SUPPLY_LOW_STATE] == $past(supply_low_state_s_q[1], 1)
    && stamp_q[9][7:4] == 4'h0)
    else $error("status stamp wrong");
  chk_osc_stop_time: assert property (
    $rose(osc_st_q) |-> $past(halt_cnt_q) ==
    tsu_pkg::OSC_CNT_W'(OSC_STOP_CYC))
    else $error("osc stop flagged at wrong time");
endmodule

// *** tb/tsu_spi_host.sv ***
`timescale 1ns/1ns
module tsu_spi_host #(
  parameter int HALF_NS = 160
) (
  input wire logic ref_clk,
  output logic sck,
  output logic cs_n,
  output logic mosi,
  input wire logic miso,
  input wire logic miso_oe_n
);
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b1;
  end

  // ----------------------------------------------------------
  // One frame: command byte, then n data bytes
  // ----------------------------------------------------------
  // Serial clock stays low between frames; a released data line
  // shows the inverse of its last bit.
  task automatic frame(input logic [7:0] cmd, input int n,
                       input logic [7:0] wd, output logic [7:0] rd [16]);
    logic [7:0] tx;
    @(posedge ref_clk);
    #1;
    cs_n = 1'b0;
    for (int b = 0; b <= n; b++) begin
      tx = (b == 0) ? cmd : wd;
      for (int i = 7; i >= 0; i--) begin
        mosi = tx[i];
        #(HALF_NS);
        sck = 1'b1;
        if (b > 0) begin
          rd[b - 1][i] = miso_oe_n ? 1'bx : miso;
        end
        #(HALF_NS);
        sck = 1'b0;
      end
    end
    #(HALF_NS);
    cs_n = 1'b1;
    mosi = ~mosi;
    #(HALF_NS);
  endtask
endmodule

// *** tb/tb_top.sv ***
`timescale 1ns/1ns
module tb_top;
  localparam int unsigned STOP_CYC = 20;
  logic ref_clk, rst_n, spi_sck, spi_cs_n, spi_mosi;
  logic spi_miso, spi_miso_oe_n, int_n, int_n_oe_n;
  logic supply_low, osc_halt, int_line;
  tsu_pkg::tsu_time_t time_now;
  int n_errors, total_checks;
  logic [7:0] rd [16];
  logic [7:0] v;

  // Interrupt line has a pull-up
  assign int_line = int_n_oe_n ? 1'b1 : int_n;

  tsu_time_stamp #(.OSC_STOP_CYC(STOP_CYC)) tsu_time_stamp_inst (
    .ref_clk(ref_clk), .rst_n(rst_n), .spi_sck(spi_sck),
    .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi), .spi_miso(spi_miso),
    .spi_miso_oe_n(spi_miso_oe_n), .int_n(int_n),
    .int_n_oe_n(int_n_oe_n), .time_now(time_now),
    .supply_low(supply_low), .osc_halt(osc_halt)
  );

  tsu_spi_host tsu_spi_host_inst (
    .ref_clk(ref_clk), .sck(spi_sck), .cs_n(spi_cs_n), .mosi(spi_mosi),
    .miso(spi_miso), .miso_oe_n(spi_miso_oe_n)
  );

  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  // ----------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic wr(input logic [2:0] b, input logic [3:0] a,
                    input logic [7:0] d);
    tsu_spi_host_inst.frame({1'b0, b, a}, 1, d, rd);
  endtask

  task automatic rdreg(input logic [2:0] b, input logic [3:0] a);
    tsu_spi_host_inst.frame({1'b1, b, a}, 1, 8'h00, rd);
    v = rd[0];
  endtask

  function automatic tsu_pkg::tsu_time_t pat(input logic [7:0] b);
    for (int k = 0; k < 9; k++) pat[71 - 8 * k -: 8] = b + 8'(k);
  endfunction

  task automatic chk_rec(input tsu_pkg::tsu_time_t p, input logic [7:0] st);
    tsu_spi_host_inst.frame({1'b1, tsu_pkg::BANK_STAMP, 4'h0}, 10, 8'h00,
                            rd);
    for (int j = 0; j < 9; j++) chk(rd[j], p[71 - 8 * j -: 8]);
    chk(rd[9], st);
  endtask

  task automatic trig();
    rdreg(tsu_pkg::BANK_STAMP, tsu_pkg::A_TRIG);
  endtask

  task automatic flag_is(input logic [7:0] f, input logic il);
    rdreg(tsu_pkg::BANK_CLK, tsu_pkg::A_FLAG);
    chk(v, f);
    chk({7'h0, int_line}, {7'h0, il});
  endtask

  // ----------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------
  task automatic t_reset();
    rdreg(tsu_pkg::BANK_CLK, tsu_pkg::A_EXT);
    chk(v, tsu_pkg::REG_RST);
    flag_is(8'h00, 1'b1);
    rdreg(tsu_pkg::BANK_STAMP, tsu_pkg::A_OVW);
    chk(v, tsu_pkg::REG_RST);
    rdreg(tsu_pkg::BANK_STORE_CTL, tsu_pkg::A_TSC3);
    chk(v, 8'h0f);
    wr(3'h3, 4'h0, 8'hff);
    rdreg(3'h3, 4'h0);
    chk(v, 8'h00);
    wr(tsu_pkg::BANK_CLK, tsu_pkg::A_EXT, 8'ha5);
    rdreg(tsu_pkg::BANK_CLK, tsu_pkg::A_EXT);
    chk(v, 8'ha5);
  endtask

  task automatic t_cmd_trigger();
    wr(tsu_pkg::BANK_CLK, tsu_pkg::A_CTRL, 8'h04);
    wr(tsu_pkg::BANK_STAMP, tsu_pkg::A_TSC0, 8'h01);
    time_now = pat(8'h10);
    trig();
    chk(v, tsu_pkg::TRIG_READ_VAL);
    chk_rec(pat(8'h10), 8'h00);
    flag_is(8'h00, 1'b1);
    wr(tsu_pkg::BANK_STAMP, tsu_pkg::A_TSC0, 8'h00);
    time_now = pat(8'h40);
    trig();
    chk(v, tsu_pkg::TRIG_READ_VAL);
    chk_rec(pat(8'h10), 8'h00);
  endtask

  task automatic t_supply();
    time_now = pat(8'h30);
    supply_low = 1'b1;
    step(10);
    flag_is(8'h00, 1'b1);
    chk_rec(pat(8'h10), 8'h00);
    supply_low = 1'b0;
    wr(tsu_pkg::BANK_STORE_CTL, tsu_pkg::A_TSC2, 8'h04);
    time_now = pat(8'h20);
    supply_low = 1'b1;
    step(10);
    time_now = pat(8'h60);
    flag_is(8'h04, 1'b0);
    chk_rec(pat(8'h20), 8'h08);
    wr(tsu_pkg::BANK_CLK, tsu_pkg::A_FLAG, 8'h04);
    flag_is(8'h04, 1'b0);
    wr(tsu_pkg::BANK_CLK, tsu_pkg::A_FLAG, 8'h00);
    flag_is(8'h00, 1'b1);
    supply_low = 1'b0;
    step(6);
  endtask

  task automatic t_irq_enable();
    supply_low = 1'b1;
    step(10);
    chk({7'h0, int_line}, 8'h00);
    wr(tsu_pkg::BANK_CLK, tsu_pkg::A_CTRL, 8'h00);
    flag_is(8'h04, 1'b1);
    wr(tsu_pkg::BANK_CLK, tsu_pkg::A_FLAG, 8'h00);
    supply_low = 1'b0;
    step(6);
    supply_low = 1'b1;
    step(10);
    flag_is(8'h04, 1'b1);
    wr(tsu_pkg::BANK_CLK, tsu_pkg::A_FLAG, 8'h00);
    supply_low = 1'b0;
  endtask

  task automatic t_osc();
    wr(tsu_pkg::BANK_STORE_CTL, tsu_pkg::A_TSC2, 8'h01);
    wr(tsu_pkg::BANK_CLK, tsu_pkg::A_CTRL, 8'h04);
    time_now = pat(8'h50);
    osc_halt = 1'b1;
    step(STOP_CYC + 10);
    flag_is(8'h01, 1'b1);
    osc_halt = 1'b0;
    step(10);
    chk({7'h0, int_line}, 8'h00);
    chk_rec(pat(8'h50), 8'h02);
    flag_is(8'h05, 1'b0);
    wr(tsu_pkg::BANK_CLK, tsu_pkg::A_FLAG, 8'h00);
    flag_is(8'h00, 1'b1);
  endtask

  task automatic t_store();
    wr(tsu_pkg::BANK_CLK, tsu_pkg::A_CTRL, 8'h04);
    wr(tsu_pkg::BANK_STAMP, tsu_pkg::A_TSC0, 8'h01);
    wr(tsu_pkg::BANK_STORE_CTL, tsu_pkg::A_TSC2, 8'h04);
    wr(tsu_pkg::BANK_STORE_CTL, tsu_pkg::A_TSC1, 8'h07);
    for (int i = 0; i < 9; i++) begin
      time_now = pat(8'h80 + 8'(16 * i));
      if (i == 0 || i == 7) begin
        // Full-select: only the event that fills the store interrupts
        supply_low = 1'b1;
        step(10);
        flag_is(8'h04, i != 7);
        wr(tsu_pkg::BANK_CLK, tsu_pkg::A_FLAG, 8'h00);
        supply_low = 1'b0;
        step(6);
      end else begin
        trig();
      end
      if (i == 7) begin
        rdreg(tsu_pkg::BANK_STORE_CTL, tsu_pkg::A_TSC3);
        chk(v, 8'h17);
      end
    end
    for (int p = 0; p < 8; p++) begin
      rdreg(3'(4 + p / 2), 4'(8 * (p % 2)));
      chk(v, 8'h81 + 8'(16 * p));
    end
    wr(tsu_pkg::BANK_STAMP, tsu_pkg::A_OVW, 8'h02);
    time_now = pat(8'h05);
    trig();
    rdreg(3'h4, 4'h0);
    chk(v, 8'h06);
  endtask

  // ----------------------------------------------------------
  // Run control
  // ----------------------------------------------------------
  task automatic wrap_up();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    #2_000_000;
    n_errors++;
    wrap_up();
  end

  initial begin
    n_errors = 0;
    total_checks = 0;
    rst_n = 1'b0;
    time_now = '0;
    supply_low = 1'b0;
    osc_halt = 1'b0;
    step(5);
    rst_n = 1'b1;
    step(4);
    t_reset();
    t_cmd_trigger();
    t_supply();
    t_irq_enable();
    t_osc();
    t_store();
    wrap_up();
  end
endmodule
